/* File: logic/ecr_aux_regs.sv */
// auxiliary control and status registers of the video encoder
// assumes line, widescreen and copy generation start pulses from the timing
// core, one data bit per clock, and comparator levels synchronous to clock
//
// How it works
// - load sense enable bit resets off; comparator results meaningless then.
// - one read-only load bit per DAC: 0 loaded, 1 not loaded.
// - 14-bit widescreen word over two registers: aspect, services, subtitles.
// - widescreen word goes out only when enabled; enable resets to 0.
// - burst begins at programmed clock position on each line.
// - burst begin resets to 33 with strap high, 25 with strap low.
// - burst ends programmed clocks after its begin position; end field resets to 29 always.
// - select bit makes shared pin teletext input (0) or sync restart (1).
// - high pulse on sync restart pin restarts sync at first line, field.
// - copy generation bytes sent lsb first right after run-in.
// - copy generation goes out only when enabled; enable resets to 0.
// - each further data byte of a transfer advances the subaddress by one.
module ecr_aux_regs (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	input wire logic i_std_strap,
	input wire logic i_red_cmp,
	input wire logic i_green_cmp,
	input wire logic i_blue_cmp,
	input wire logic i_shared_pin,
	input wire logic i_line_start,
	input wire logic i_wss_start,
	input wire logic i_cg_start,
	output logic o_load_sense_enable,
	output logic o_burst_gate,
	output logic o_teletext_stream_in,
	output logic o_sync_restart,
	output logic o_widescreen_bit,
	output logic o_widescreen_valid,
	output logic o_copygen_bit,
	output logic o_copygen_valid
);

	ecr_pkg::ecr_wr_s wr;
	logic [7:0] sub;
	logic [7:0] rdata;
	logic load_sense_enable_ff;
	logic [ecr_pkg::WSS_W-1:0] widescreen_word_ff;
	logic widescreen_out_enable_ff;
	logic [7:0] burst_begin_pos_ff;
	logic [ecr_pkg::BURST_END_W-1:0] burst_finish_pos_ff;
	logic sync_restart_select_ff;
	logic [7:0] copygen_byte0_ff;
	logic [7:0] copygen_byte1_ff;
	logic [ecr_pkg::CG2_W-1:0] copygen_byte2_ff;
	logic copygen_out_enable_ff;
	logic sda_out_ff;
	logic pin_q_ff;
	logic teletext_ff;
	logic sync_restart_ff;
	logic [7:0] pos_ff;
	logic burst_gate_ff;
	logic [ecr_pkg::WSS_W-1:0] wss_sh_ff;
	logic [4:0] wss_cnt_ff;
	logic [ecr_pkg::CG_W-1:0] cg_sh_ff;
	logic [4:0] cg_cnt_ff;
	logic [8:0] burst_stop;

	function automatic logic hit(input ecr_pkg::ecr_wr_s w,
		input logic [7:0] ofs);
		hit = w.valid && (w.addr == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// serial bus slave
	ecr_serial_slave u_slave (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.i_rdata(rdata),
		.o_wr(wr),
		.o_sub(sub),
		.o_sda_oe_n(o_sda_oe_n)
	);

	// open-drain: only ever pulls low, enable low selects the pull
	always_ff @(posedge i_clk_sys) begin
		sda_out_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			load_sense_enable_ff <= 1'b0;
		end else if (hit(wr, ecr_pkg::OFS_SENSE)) begin
			load_sense_enable_ff <= wr.data[ecr_pkg::SENSE_EN_BIT];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			widescreen_word_ff <= '0;
			widescreen_out_enable_ff <= 1'b0;
		end else begin
			if (hit(wr, ecr_pkg::OFS_WSS_LO)) begin
				widescreen_word_ff[7:0] <= wr.data;
			end
			if (hit(wr, ecr_pkg::OFS_WSS_HI)) begin
				widescreen_word_ff[ecr_pkg::WSS_W-1:8] <=
					wr.data[ecr_pkg::WSS_HI_W-1:0];
				widescreen_out_enable_ff <= wr.data[ecr_pkg::WSS_EN_BIT];
			end
		end
	end

	// strap is caught by the synchronous reset itself, so it must be
	// settled before the reset is released
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			burst_begin_pos_ff <= i_std_strap ? ecr_pkg::BURST_BEGIN_PAL :
				ecr_pkg::BURST_BEGIN_NTSC;
			burst_finish_pos_ff <= ecr_pkg::BURST_END_RST;
			sync_restart_select_ff <= 1'b0;
		end else begin
			if (hit(wr, ecr_pkg::OFS_BURST_BEGIN)) begin
				burst_begin_pos_ff <= wr.data;
			end
			if (hit(wr, ecr_pkg::OFS_BURST_END)) begin
				burst_finish_pos_ff <= wr.data[ecr_pkg::BURST_END_W-1:0];
				sync_restart_select_ff <= wr.data[ecr_pkg::SYNC_SEL_BIT];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			copygen_byte0_ff <= ecr_pkg::BYTE_RST;
			copygen_byte1_ff <= ecr_pkg::BYTE_RST;
			copygen_byte2_ff <= '0;
			copygen_out_enable_ff <= 1'b0;
		end else begin
			if (hit(wr, ecr_pkg::OFS_CG0)) begin
				copygen_byte0_ff <= wr.data;
			end
			if (hit(wr, ecr_pkg::OFS_CG1)) begin
				copygen_byte1_ff <= wr.data;
			end
			if (hit(wr, ecr_pkg::OFS_CG2)) begin
				copygen_byte2_ff <= wr.data[ecr_pkg::CG2_W-1:0];
				copygen_out_enable_ff <= wr.data[ecr_pkg::CG_EN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register reads; unmapped subaddresses read as zero
	always_comb begin
		rdata = 8'h00;
		unique case (sub)
			ecr_pkg::OFS_SENSE: begin
				rdata[ecr_pkg::SENSE_EN_BIT] = load_sense_enable_ff;
				// gated so a disabled sense reads deterministic zeros
				rdata[ecr_pkg::RED_BIT] = load_sense_enable_ff &
					i_red_cmp;
				rdata[ecr_pkg::GREEN_BIT] = load_sense_enable_ff &
					i_green_cmp;
				rdata[ecr_pkg::BLUE_BIT] = load_sense_enable_ff &
					i_blue_cmp;
			end
			ecr_pkg::OFS_WSS_LO: rdata = widescreen_word_ff[7:0];
			ecr_pkg::OFS_WSS_HI: begin
				rdata[ecr_pkg::WSS_HI_W-1:0] =
					widescreen_word_ff[ecr_pkg::WSS_W-1:8];
				rdata[ecr_pkg::WSS_EN_BIT] = widescreen_out_enable_ff;
			end
			ecr_pkg::OFS_BURST_BEGIN: rdata = burst_begin_pos_ff;
			ecr_pkg::OFS_BURST_END: begin
				rdata[ecr_pkg::BURST_END_W-1:0] = burst_finish_pos_ff;
				rdata[ecr_pkg::SYNC_SEL_BIT] = sync_restart_select_ff;
			end
			ecr_pkg::OFS_CG0: rdata = copygen_byte0_ff;
			ecr_pkg::OFS_CG1: rdata = copygen_byte1_ff;
			ecr_pkg::OFS_CG2: begin
				rdata[ecr_pkg::CG2_W-1:0] = copygen_byte2_ff;
				rdata[ecr_pkg::CG_EN_BIT] = copygen_out_enable_ff;
			end
			default: rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// shared pin: teletext stream or sync restart
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			pin_q_ff <= 1'b0;
			teletext_ff <= 1'b0;
			sync_restart_ff <= 1'b0;
		end else begin
			pin_q_ff <= i_shared_pin;
			teletext_ff <= ~sync_restart_select_ff & i_shared_pin;
			sync_restart_ff <= sync_restart_select_ff & i_shared_pin &
				~pin_q_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// burst gate; finish position counts from the begin position
	assign burst_stop = {1'b0, burst_begin_pos_ff} +
		{3'b000, burst_finish_pos_ff};

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			pos_ff <= 8'h00;
			burst_gate_ff <= 1'b0;
		end else if (i_line_start || sync_restart_ff) begin
			pos_ff <= 8'h00;
			burst_gate_ff <= 1'b0;
		end else begin
			if (pos_ff != 8'hFF) begin
				pos_ff <= pos_ff + 8'h01;
			end
			if (pos_ff == burst_begin_pos_ff) begin
				burst_gate_ff <= 1'b1;
			end else if ({1'b0, pos_ff} == burst_stop) begin
				burst_gate_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serialisers, lsb first, one bit per clock after the start pulse
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			wss_sh_ff <= '0;
			wss_cnt_ff <= 5'h00;
		end else if (i_wss_start && widescreen_out_enable_ff) begin
			wss_sh_ff <= widescreen_word_ff;
			wss_cnt_ff <= 5'(ecr_pkg::WSS_W);
		end else if (wss_cnt_ff != 5'h00) begin
			wss_sh_ff <= {1'b0, wss_sh_ff[ecr_pkg::WSS_W-1:1]};
			wss_cnt_ff <= wss_cnt_ff - 5'h01;
		end
	end

	// check bits sit in the msbs as supplied by the host
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cg_sh_ff <= '0;
			cg_cnt_ff <= 5'h00;
		end else if (i_cg_start && copygen_out_enable_ff) begin
			cg_sh_ff <= {copygen_byte2_ff, copygen_byte1_ff,
				copygen_byte0_ff};
			cg_cnt_ff <= 5'(ecr_pkg::CG_W);
		end else if (cg_cnt_ff != 5'h00) begin
			cg_sh_ff <= {1'b0, cg_sh_ff[ecr_pkg::CG_W-1:1]};
			cg_cnt_ff <= cg_cnt_ff - 5'h01;
		end
	end

	logic wss_bit_ff;
	logic wss_valid_ff;
	logic cg_bit_ff;
	logic cg_valid_ff;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			wss_bit_ff <= 1'b0;
			wss_valid_ff <= 1'b0;
			cg_bit_ff <= 1'b0;
			cg_valid_ff <= 1'b0;
		end else begin
			wss_valid_ff <= (wss_cnt_ff != 5'h00);
			wss_bit_ff <= (wss_cnt_ff != 5'h00) & wss_sh_ff[0];
			cg_valid_ff <= (cg_cnt_ff != 5'h00);
			cg_bit_ff <= (cg_cnt_ff != 5'h00) & cg_sh_ff[0];
		end
	end

	assign o_sda_out = sda_out_ff;
	assign o_load_sense_enable = load_sense_enable_ff;
	assign o_burst_gate = burst_gate_ff;
	assign o_teletext_stream_in = teletext_ff;
	assign o_sync_restart = sync_restart_ff;
	assign o_widescreen_bit = wss_bit_ff;
	assign o_widescreen_valid = wss_valid_ff;
	assign o_copygen_bit = cg_bit_ff;
	assign o_copygen_valid = cg_valid_ff;

endmodule

/* File: logic/ecr_pkg.sv */
// constants and carrier types for the encoder auxiliary register bank
// assumes a byte-wide register space behind a two-wire serial slave
package ecr_pkg;

	////////////////////////////////////////////////////////////////////////
	// serial bus
	localparam logic [6:0] SLAVE_ADDR = 7'h44;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_SENSE = 8'h1B;
	localparam logic [7:0] OFS_WSS_LO = 8'h26;
	localparam logic [7:0] OFS_WSS_HI = 8'h27;
	localparam logic [7:0] OFS_BURST_BEGIN = 8'h28;
	localparam logic [7:0] OFS_BURST_END = 8'h29;
	localparam logic [7:0] OFS_CG0 = 8'h2A;
	localparam logic [7:0] OFS_CG1 = 8'h2B;
	localparam logic [7:0] OFS_CG2 = 8'h2C;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int SENSE_EN_BIT = 7;
	localparam int RED_BIT = 2;
	localparam int GREEN_BIT = 1;
	localparam int BLUE_BIT = 0;
	localparam int WSS_EN_BIT = 7;
	localparam int WSS_HI_W = 6;
	localparam int WSS_W = 14;
	localparam int SYNC_SEL_BIT = 7;
	localparam int BURST_END_W = 6;
	localparam int CG_EN_BIT = 7;
	localparam int CG2_W = 4;
	localparam int CG_W = 20;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] BURST_BEGIN_PAL = 8'h21;
	localparam logic [7:0] BURST_BEGIN_NTSC = 8'h19;
	localparam logic [5:0] BURST_END_RST = 6'h1D;
	localparam logic [7:0] BYTE_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} ecr_wr_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_SUB,
		ST_ACK_SUB,
		ST_WDATA,
		ST_ACK_W,
		ST_RDATA,
		ST_MACK
	} ecr_state_e;

endpackage

/* File: logic/ecr_serial_slave.sv */
// two-wire serial slave: address match, subaddress, byte writes and reads
// assumes scl and sda are synchronous to the clock and far slower than it
module ecr_serial_slave (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [7:0] i_rdata,
	output ecr_pkg::ecr_wr_s o_wr,
	output logic [7:0] o_sub,
	output logic o_sda_oe_n
);

	ecr_pkg::ecr_state_e state_ff;
	logic scl_q_ff;
	logic sda_q_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff;
	logic [7:0] sub_ff;
	logic rw_ff;
	logic oe_n_ff;
	ecr_pkg::ecr_wr_s wr_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic full;

	assign scl_rise = i_scl & ~scl_q_ff;
	assign scl_fall = ~i_scl & scl_q_ff;
	assign start_c = i_scl & scl_q_ff & sda_q_ff & ~i_sda;
	assign stop_c = i_scl & scl_q_ff & ~sda_q_ff & i_sda;
	assign full = (cnt_ff == ecr_pkg::BITS_PER_BYTE);

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= i_scl;
			sda_q_ff <= i_sda;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// protocol engine
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_ff <= ecr_pkg::ST_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			sub_ff <= 8'h00;
			rw_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			wr_ff <= '0;
		end else begin
			wr_ff.valid <= 1'b0;
			if (start_c) begin
				state_ff <= ecr_pkg::ST_ADDR;
				cnt_ff <= 4'h0;
				oe_n_ff <= 1'b1;
			end else if (stop_c) begin
				state_ff <= ecr_pkg::ST_IDLE;
				oe_n_ff <= 1'b1;
			end else if (scl_rise) begin
				unique case (state_ff)
					ecr_pkg::ST_ADDR, ecr_pkg::ST_SUB, ecr_pkg::ST_WDATA: begin
						sh_ff <= {sh_ff[6:0], i_sda};
						cnt_ff <= cnt_ff + 4'h1;
					end
					ecr_pkg::ST_RDATA: cnt_ff <= cnt_ff + 4'h1;
					ecr_pkg::ST_MACK: begin
						// a not-acknowledge ends the read burst
						if (i_sda) begin
							state_ff <= ecr_pkg::ST_IDLE;
						end
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				unique case (state_ff)
					ecr_pkg::ST_ADDR: begin
						if (full) begin
							cnt_ff <= 4'h0;
							if (sh_ff[7:1] == ecr_pkg::SLAVE_ADDR) begin
								rw_ff <= sh_ff[0];
								oe_n_ff <= 1'b0;
								state_ff <= ecr_pkg::ST_ACK_ADDR;
							end else begin
								state_ff <= ecr_pkg::ST_IDLE;
							end
						end
					end
					ecr_pkg::ST_SUB: begin
						if (full) begin
							cnt_ff <= 4'h0;
							sub_ff <= sh_ff;
							oe_n_ff <= 1'b0;
							state_ff <= ecr_pkg::ST_ACK_SUB;
						end
					end
					ecr_pkg::ST_WDATA: begin
						if (full) begin
							cnt_ff <= 4'h0;
							wr_ff.valid <= 1'b1;
							wr_ff.addr <= sub_ff;
							wr_ff.data <= sh_ff;
							oe_n_ff <= 1'b0;
							state_ff <= ecr_pkg::ST_ACK_W;
						end
					end
					ecr_pkg::ST_ACK_ADDR, ecr_pkg::ST_MACK: begin
						if (rw_ff) begin
							sh_ff <= {i_rdata[6:0], 1'b0};
							oe_n_ff <= i_rdata[7];
							state_ff <= ecr_pkg::ST_RDATA;
						end else begin
							oe_n_ff <= 1'b1;
							state_ff <= ecr_pkg::ST_SUB;
						end
					end
					ecr_pkg::ST_ACK_SUB, ecr_pkg::ST_ACK_W: begin
						oe_n_ff <= 1'b1;
						state_ff <= ecr_pkg::ST_WDATA;
						if (state_ff == ecr_pkg::ST_ACK_W) begin
							sub_ff <= sub_ff + 8'h01;
						end
					end
					ecr_pkg::ST_RDATA: begin
						if (full) begin
							cnt_ff <= 4'h0;
							oe_n_ff <= 1'b1;
							sub_ff <= sub_ff + 8'h01;
							state_ff <= ecr_pkg::ST_MACK;
						end else begin
							oe_n_ff <= sh_ff[7];
							sh_ff <= {sh_ff[6:0], 1'b0};
						end
					end
					default: ;
				endcase
			end
		end
	end

	assign o_wr = wr_ff;
	assign o_sub = sub_ff;
	assign o_sda_oe_n = oe_n_ff;

endmodule

/* File: sim/ecr_aux_regs_bench.sv */
// self-checking bench for the auxiliary register bank
// assumes the host model and monitor are compiled alongside
module ecr_aux_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, pin = 1'b0;
	logic red = 1'b0, green = 1'b0, blue = 1'b0;
	logic ls = 1'b0, ws = 1'b0, cs = 1'b0, meas = 1'b0, gate_d = 1'b0;
	logic scl, sda, oe_n, gate, rst_p, wb, wv, cb, cv, rd_stb;
	logic lse, tt, sda_lo;
	logic [7:0] rd_val, b, exp_q[$];
	logic [13:0] wide_screen_word_low;
	logic [19:0] cg;
	int fails = 0, samples_checked = 0, cyc = 0, pos = 0;
	int seed = 32'h8F67DFE3;
	always #25 clk = ~clk;
	ecr_aux_regs uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_lo), .o_sda_oe_n(oe_n),
		.i_std_strap(strap),
		.i_red_cmp(red), .i_green_cmp(green), .i_blue_cmp(blue),
		.i_shared_pin(pin), .i_line_start(ls), .i_wss_start(ws),
		.i_cg_start(cs), .o_load_sense_enable(lse), .o_burst_gate(gate),
		.o_teletext_stream_in(tt), .o_sync_restart(rst_p),
		.o_widescreen_bit(wb), .o_widescreen_valid(wv),
		.o_copygen_bit(cb), .o_copygen_valid(cv));
	ecr_host_model host (.i_clk_sys(clk), .i_sda_oe_n(oe_n),
		.i_sda_out(sda_lo), .o_scl(scl),
		.o_sda(sda), .o_rd_stb(rd_stb), .o_rd_val(rd_val));
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (fails == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got);
		logic [7:0] e;
		e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
		samples_checked++;
		if (got !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		w(1);
		s = 1'b0;
		w(1);
	endtask
	task automatic do_reset(input logic s);
		strap = s;
		rst_n = 1'b0;
		w(4);
		rst_n = 1'b1;
		w(2);
	endtask
	// every result seen at the outputs takes the oldest note
	always @(posedge clk) begin
		cyc++;
		if (cyc > 40000) begin
			fails++;
			end_sim();
		end
		if (rd_stb) cmp(rd_val);
		if (wv) cmp({7'h00, wb});
		if (cv) cmp({7'h00, cb});
		if (meas && gate && !gate_d) cmp(pos[7:0]);
		if (rst_p) cmp(8'h5A);
		gate_d <= gate;
		pos <= ls ? 0 : pos + 1;
	end
	initial begin
		do_reset(1'b1);
		exp_q = {8'h00, 8'h00, 8'h21, 8'h1D};
		host.rd(8'h26, 4);
		{red, green, blue} = 3'($random(seed));
		exp_q = {8'h00, 8'h00, 8'h00};
		host.rd(8'h2C, 2);
		host.rd(8'h1B, 1);
		host.wr(8'h1C, 1, 24'h0000FF);
		exp_q.push_back(8'h00);
		host.rd(8'h1C, 1);
		pulse(ws);
		pulse(cs);
		w(30);
		host.wr(8'h1B, 1, 24'h000080);
		exp_q.push_back(8'h01);
		cmp({7'h00, lse});
		{red, green, blue} = 3'($random(seed));
		exp_q.push_back({5'h10, red, green, blue});
		host.rd(8'h1B, 1);
		host.wr(8'h1B, 1, 24'h000000);
		exp_q.push_back(8'h00);
		cmp({7'h00, lse});
		exp_q.push_back(8'h00);
		host.rd(8'h1B, 1);
		wide_screen_word_low = 14'($random(seed));
		host.wr(8'h26, 2, {8'h00, 2'b10, wide_screen_word_low});
		for (int i = 0; i < 14; i++) exp_q.push_back({7'h00, wide_screen_word_low[i]});
		pulse(ws);
		w(20);
		// random payload stands in for host check bits in the msbs
		cg = 20'($random(seed));
		host.wr(8'h2A, 3, {4'h8, cg});
		for (int i = 0; i < 20; i++) exp_q.push_back({7'h00, cg[i]});
		pulse(cs);
		w(30);
		b = 8'h05 + {4'h0, 4'($random(seed))};
		host.wr(8'h28, 1, {16'h0000, b});
		exp_q.push_back(b + 8'h01);
		meas = 1'b1;
		pulse(ls);
		w(int'(b) + 40);
		meas = 1'b0;
		for (int i = 0; i < 20; i++) begin
			pin = 1'($random(seed));
			w(2);
			exp_q.push_back({7'h00, pin});
			cmp({7'h00, tt});
		end
		pin = 1'b0;
		host.wr(8'h29, 1, 24'h00009D);
		exp_q.push_back(8'h5A);
		pulse(pin);
		w(10);
		do_reset(1'b0);
		exp_q.push_back(8'h19);
		host.rd(8'h28, 1);
		w(5);
		if (exp_q.size() != 0) fails++;
		end_sim();
	end
endmodule

bind ecr_aux_regs ecr_aux_regs_monitor mon (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_shared_pin(i_shared_pin),
	.i_wss_start(i_wss_start), .i_cg_start(i_cg_start),
	.i_line_start(i_line_start),
	.o_sync_restart(o_sync_restart),
	.o_teletext_stream_in(o_teletext_stream_in),
	.o_widescreen_valid(o_widescreen_valid),
	.o_copygen_valid(o_copygen_valid), .o_burst_gate(o_burst_gate));

/* File: sim/ecr_aux_regs_monitor.sv */
// timing checks on the auxiliary register bank outputs
// assumes burst end field stays at its reset value while checked
module ecr_aux_regs_monitor (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_shared_pin,
	input wire logic i_wss_start,
	input wire logic i_cg_start,
	input wire logic i_line_start,
	input wire logic o_sync_restart,
	input wire logic o_teletext_stream_in,
	input wire logic o_widescreen_valid,
	input wire logic o_copygen_valid,
	input wire logic o_burst_gate
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	int wss_run;
	int cg_run;
	int gate_run;
	// run lengths of each qualifier, cleared whenever it drops
	always_ff @(posedge i_clk_sys) begin
		wss_run <= (i_rst_n && o_widescreen_valid) ? wss_run + 1 : 0;
		cg_run <= (i_rst_n && o_copygen_valid) ? cg_run + 1 : 0;
		gate_run <= (i_rst_n && o_burst_gate) ? gate_run + 1 : 0;
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_pulse;
		o_sync_restart ##1 !o_sync_restart;
	endsequence
	chk_tt_follow: assert property (o_teletext_stream_in |->
		$past(i_shared_pin)) else $error("teletext not following pin");
	chk_restart_edge: assert property (o_sync_restart |->
		$past(i_shared_pin) && !$past(i_shared_pin, 2)
		&& !o_teletext_stream_in) else $error("restart without pin rise");
	chk_restart_single: assert property ($rose(o_sync_restart) |->
		s_pulse) else $error("restart pulse too long");
	chk_wss_length: assert property ($fell(o_widescreen_valid) |->
		wss_run == 14) else $error("widescreen length wrong");
	chk_cg_length: assert property ($fell(o_copygen_valid) |->
		cg_run == 20) else $error("copy generation length wrong");
	chk_wss_cause: assert property ($rose(o_widescreen_valid) |->
		$past(i_wss_start) || $past(i_wss_start, 2))
		else $error("widescreen without start");
	chk_cg_cause: assert property ($rose(o_copygen_valid) |->
		$past(i_cg_start) || $past(i_cg_start, 2))
		else $error("copy generation without start");
	// a line start or restart may legally cut a burst short
	chk_burst_length: assert property ($fell(o_burst_gate) &&
		!$past(i_line_start) && !$past(o_sync_restart) |->
		gate_run == 29) else $error("burst length wrong");
endmodule

/* File: sim/ecr_host_model.sv */
// two-wire serial host: byte writes and auto-increment reads
// assumes sda pulled high; device drives its data pin while enable is low
module ecr_host_model (
	input wire logic i_clk_sys,
	input wire logic i_sda_oe_n,
	input wire logic i_sda_out,
	output logic o_scl,
	output logic o_sda,
	output logic o_rd_stb,
	output logic [7:0] o_rd_val
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int P = 5;
	logic drv;
	logic smp;
	// unknown enable before reset counts as released; driven shows device bit
	assign o_sda = (i_sda_oe_n !== 1'b0) ? drv : (drv & i_sda_out);
	initial begin
		o_scl = 1'b1;
		drv = 1'b1;
		o_rd_stb = 1'b0;
		o_rd_val = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic tk(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic clk_bit();
		tk(P);
		o_scl = 1'b1;
		tk(P);
		smp = o_sda;
		o_scl = 1'b0;
		tk(P);
	endtask
	task automatic start();
		drv = 1'b0;
		tk(P);
		o_scl = 1'b0;
		tk(P);
	endtask
	task automatic stop();
		drv = 1'b0;
		tk(P);
		o_scl = 1'b1;
		tk(P);
		drv = 1'b1;
		tk(P);
	endtask
	// msb first; a read byte leaves sda released and answers with ack
	task automatic xb(input logic [7:0] b, input logic rd, input logic ack,
		output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			drv = rd | b[i];
			clk_bit();
			r[i] = smp;
		end
		drv = rd ? ack : 1'b1;
		clk_bit();
	endtask
	task automatic wr(input logic [7:0] sub, input int n,
		input logic [23:0] d);
		logic [7:0] r;
		start();
		xb(8'h88, 1'b0, 1'b0, r);
		xb(sub, 1'b0, 1'b0, r);
		for (int i = 0; i < n; i++) xb(d[8 * i +: 8], 1'b0, 1'b0, r);
		stop();
	endtask
	// last byte gets no ack so the device lets go of sda
	task automatic rd(input logic [7:0] sub, input int n);
		logic [7:0] r;
		wr(sub, 0, 24'h000000);
		start();
		xb(8'h89, 1'b0, 1'b0, r);
		for (int i = 0; i < n; i++) begin
			xb(8'h00, 1'b1, i == n - 1, r);
			o_rd_val = r;
			o_rd_stb = 1'b1;
			tk(1);
			o_rd_stb = 1'b0;
		end
		stop();
	endtask
endmodule
